// ---- bench/gpm_pad_mode_checker.sv ----
// Checker for the pad mode block: power down overrides, host pad modes,
// read data behaviour.
// Assumes it is bound into gpm_pad_mode and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "gpm_consts.vh"
module gpm_pad_mode_checker #(
    parameter P3_PINS = 6,
    parameter P7_PINS = 3
) (
    // Clock, reset and register access.
    input wire logic               clk_sys_in,
    input wire logic               rst_in,
    input wire logic [7:0]         sfr_addr_in,
    input wire logic [7:0]         sfr_wdata_in,
    input wire logic               sfr_wr_in,
    input wire logic               sfr_rd_in,
    input wire logic [7:0]         sfr_rdata_out,
    // Power state.
    input wire logic               hard_power_down_in,
    input wire logic               processor_power_down_in,
    // Port pads.
    input wire logic [P3_PINS-1:0] p3_pad_level_in,
    input wire logic [P3_PINS-1:0] p3_pin_out,
    input wire logic [P3_PINS-1:0] p3_pin_oe_out,
    input wire logic [P3_PINS-1:0] p3_pull_down_en_n_out,
    input wire logic [P3_PINS-1:0] p3_weak_hold_out,
    input wire logic [P3_PINS-1:0] p3_very_weak_pu_out,
    input wire logic [P7_PINS-1:0] p7_pad_level_in,
    input wire logic [P7_PINS-1:0] p7_pin_oe_out,
    input wire logic [P7_PINS-1:0] p7_weak_hold_out,
    input wire logic [P7_PINS-1:0] p7_very_weak_pu_out,
    // Host pads.
    input wire logic [3:0]         host_pad_value_in,
    input wire logic [3:0]         host_pin_out,
    input wire logic [3:0]         host_pin_oe_out,
    input wire logic [1:0]         host_sel_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    // Register strobes that start a multi-cycle check.
    sequence host_wr_s;
        sfr_wr_in && sfr_addr_in == `GPM_ADDR_HOST_CFG;
    endsequence
    sequence blank_rd_s;
        sfr_rd_in && sfr_addr_in == 8'h00;
    endsequence

    // Power down overrides of the port pads, and the port 3 pull-down enable.
    p3_power_down_a: assert property (
        hard_power_down_in && !processor_power_down_in |-> p3_pin_oe_out == '0
        && &p3_very_weak_pu_out && p3_weak_hold_out == p3_pad_level_in)
        else $error("port 3 pads not quasi in power down");
    p7_power_down_a: assert property (
        hard_power_down_in |-> p7_pin_oe_out == '0
        && &p7_very_weak_pu_out && p7_weak_hold_out == p7_pad_level_in)
        else $error("port 7 pads not quasi in power down");
    int0_hold_a: assert property (
        processor_power_down_in |-> p3_weak_hold_out[`GPM_INT0_BIT])
        else $error("interrupt pin hold not forced");
    pull_down_a: assert property (
        p3_pull_down_en_n_out == ~(p3_pin_oe_out & ~p3_pin_out))
        else $error("pull down enable wrong");

    // Register side.
    host_sel_a: assert property (
        host_wr_s |=> host_sel_out == $past(sfr_wdata_in[1:0]))
        else $error("host select not loaded");
    blank_read_a: assert property (
        blank_rd_s |=> sfr_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (
        !sfr_rd_in |=> $stable(sfr_rdata_out))
        else $error("read data moved without read");

    // Host pad modes for the I2C, fast UART and SPI select codes.
    i2c_pads_a: assert property (
        host_sel_out == `GPM_HOST_SEL_I2C |-> host_pin_out[1:0] == 2'h0
        && host_pin_oe_out[1:0] == ~host_pad_value_in[1:0])
        else $error("i2c pads not open drain");
    uart_pads_a: assert property (
        host_sel_out == `GPM_HOST_SEL_HSU |-> !host_pin_oe_out[0]
        && host_pin_oe_out[1] && host_pin_out[1] == host_pad_value_in[1])
        else $error("uart pads wrong");
    spi_pads_a: assert property (
        host_sel_out == `GPM_HOST_SEL_SPI |-> host_pin_oe_out == 4'h2
        && host_pin_out[1] == host_pad_value_in[1])
        else $error("spi pads wrong");
endmodule
bind gpm_pad_mode gpm_pad_mode_checker #(.P3_PINS(P3_PINS), .P7_PINS(P7_PINS)) u_chk (.*);
`default_nettype wire

// ---- bench/gpm_pad_world.sv ----
// Board side of the pads: a pull-up resistor on every pin.
// Assumes a high drive enable means the block drives the pin.
`timescale 1ns/1ps
`default_nettype none
module gpm_pad_world #(
    parameter W = 6
) (
    // Pad drive from the block.
    input  wire logic [W-1:0] oe_in,
    input  wire logic [W-1:0] out_in,
    // Resolved pin level.
    output wire logic [W-1:0] level_out
);
    // An undriven pin is pulled high by its resistor.
    assign level_out = (oe_in & out_in) | ~oe_in;
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// Testbench for the pad mode block: register tasks, mode table, power down.
// Assumes pull-up resistors on all pins, modelled by gpm_pad_world.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic       clk_sys_in = 1'b0;
    logic       rst_in = 1'b1;
    logic [7:0] sfr_addr_in = 8'h00;
    logic [7:0] sfr_wdata_in = 8'h00;
    logic       sfr_wr_in = 1'b0;
    logic       sfr_rd_in = 1'b0;
    logic       hard_power_down_in = 1'b0;
    logic       processor_power_down_in = 1'b0;
    logic [3:0] host_pad_value_in = 4'ha;
    wire logic [7:0] sfr_rdata_out;
    wire logic [5:0] p3_pad_level_in, p3_pin_out, p3_pin_oe_out, p3_pull_down_en_n_out;
    wire logic [5:0] p3_weak_hold_out, p3_very_weak_pu_out;
    wire logic [2:0] p7_pad_level_in, p7_pin_out, p7_pin_oe_out, p7_pull_down_en_n_out;
    wire logic [2:0] p7_weak_hold_out, p7_very_weak_pu_out;
    wire logic [3:0] host_pad_level_in, host_pin_out, host_pin_oe_out;
    wire logic [3:0] host_pull_down_en_n_out, host_weak_hold_out, host_very_weak_pu_out;
    wire logic [1:0] host_sel_out;
    // Expected values per mode (B,A) with value 0x05, and per host select.
    logic [7:0] e_oe [4] = '{8'h3a, 8'h3a, 8'h00, 8'h3f};
    logic [7:0] e_rd [4] = '{8'h05, 8'h05, 8'h3f, 8'h05};
    logic [3:0] e_ho [4] = '{4'h2, 4'h1, 4'h2, 4'h0};
    logic [3:0] e_hm [4] = '{4'h3, 4'h3, 4'hf, 4'hf};
    logic [3:0] e_hv [4] = '{4'h2, 4'h0, 4'h2, 4'h0};
    integer n_errors = 0;
    integer num_checks = 0;
    integer m;

    // Clock at 100 MHz.
    always #5 clk_sys_in = ~clk_sys_in;

    gpm_pad_mode #(.P3_PINS(6), .P7_PINS(3)) DUT (.*);
    gpm_pad_world #(.W(6)) u_p3 (.oe_in(p3_pin_oe_out), .out_in(p3_pin_out),
        .level_out(p3_pad_level_in));
    gpm_pad_world #(.W(3)) u_p7 (.oe_in(p7_pin_oe_out), .out_in(p7_pin_out),
        .level_out(p7_pad_level_in));
    gpm_pad_world #(.W(4)) u_hp (.oe_in(host_pin_oe_out), .out_in(host_pin_out),
        .level_out(host_pad_level_in));

    // Compares one value and counts the result.
    task chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe, taken at the second edge.
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        sfr_addr_in <= a;
        sfr_wdata_in <= d;
        sfr_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        sfr_wr_in <= 1'b0;
    endtask

    // One-cycle read strobe; data is valid after the taking edge.
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys_in);
        sfr_addr_in <= a;
        sfr_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        sfr_rd_in <= 1'b0;
        #1 chk(sfr_rdata_out, exp);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Cuts a hung run short.
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        n_errors = n_errors + 1;
        print_verdict;
    end

    // Main sequence.
    initial begin
        repeat (2) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        rd(8'hfc, 8'hff);
        rd(8'hfd, 8'h00);
        rd(8'hf4, 8'hff);
        rd(8'hf5, 8'h00);
        rd(8'hb0, 8'h3f);
        rd(8'hf7, 8'h07);
        chk({2'b00, p3_very_weak_pu_out}, 8'h3f);
        $display("test reset done");
        // Every mode on all pins of both ports.
        for (m = 0; m < 4; m = m + 1) begin
            wr(8'hfc, m[0] ? 8'hff : 8'h00);
            wr(8'hfd, m[1] ? 8'hff : 8'h00);
            wr(8'hf4, m[0] ? 8'hff : 8'h00);
            wr(8'hf5, m[1] ? 8'hff : 8'h00);
            wr(8'hf7, 8'h05);
            wr(8'hb0, 8'h05);
            #1;
            if (m == 1) begin
                chk({2'b00, p3_pin_oe_out}, 8'h3f);
                chk({2'b00, p3_pin_out}, 8'h05);
                @(posedge clk_sys_in);
                #1;
                chk({2'b00, p3_very_weak_pu_out}, 8'h05);
                chk({2'b00, p3_weak_hold_out}, 8'h05);
            end
            chk({2'b00, p3_pin_oe_out}, e_oe[m]);
            chk({5'b0, p7_pin_oe_out}, {5'b0, e_oe[m][2:0]});
            if (m != 2) chk({2'b00, p3_pull_down_en_n_out}, 8'h05);
            if (m != 2) chk({5'b0, p7_pull_down_en_n_out}, 8'h05);
            if (m == 2) chk({2'b00, p3_very_weak_pu_out | p3_weak_hold_out}, 8'h00);
            if (m == 3) chk({2'b00, p3_pin_out}, 8'h05);
            if (m == 3) chk({5'b0, p7_pin_out}, 8'h05);
            rd(8'hb0, e_rd[m]);
            $display("test mode %0d done", m);
        end
        // Changing pin 0 alone leaves the other push-pull pins driving.
        wr(8'hfc, 8'hfe);
        #1;
        chk({2'b00, p3_pin_oe_out}, 8'h3e);
        chk({2'b00, p3_pin_out & 6'h3e}, 8'h04);
        // Hard power down, then processor power down on an input pin.
        @(posedge clk_sys_in);
        hard_power_down_in <= 1'b1;
        @(posedge clk_sys_in);
        #1;
        chk({2'b00, p3_pin_oe_out | ~p3_very_weak_pu_out}, 8'h00);
        chk({2'b00, p3_weak_hold_out}, 8'h3f);
        chk({5'b0, p7_pin_oe_out | ~p7_very_weak_pu_out}, 8'h00);
        chk({5'b0, p7_weak_hold_out}, 8'h07);
        @(posedge clk_sys_in);
        hard_power_down_in <= 1'b0;
        wr(8'hfc, 8'h00);
        processor_power_down_in <= 1'b1;
        @(posedge clk_sys_in);
        #1;
        chk({2'b00, p3_weak_hold_out}, 8'h04);
        @(posedge clk_sys_in);
        processor_power_down_in <= 1'b0;
        $display("test power down done");
        // Every host select code.
        for (m = 0; m < 4; m = m + 1) begin
            wr(8'hab, {6'h3c, m[1:0]});
            rd(8'hab, {6'h3c, m[1:0]});
            chk({6'h00, host_sel_out}, {6'h00, m[1:0]});
            chk({4'h0, host_pin_oe_out & e_hm[m]}, {4'h0, e_ho[m]});
            chk({4'h0, host_pin_out & host_pin_oe_out & e_hm[m]}, {4'h0, e_hv[m]});
            chk({4'h0, host_pull_down_en_n_out}, (m == 1) ? 8'h0e : 8'h0f);
            chk({4'h0, host_weak_hold_out | host_very_weak_pu_out}, 8'h00);
            $display("test host %0d done", m);
        end
        // Unmapped address is ignored and reads zero.
        wr(8'h00, 8'h5a);
        rd(8'h00, 8'h00);
        rd(8'hfd, 8'hff);
        $display("test unmapped done");
        print_verdict;
    end
endmodule
`default_nettype wire

// ---- design/gpm_consts.vh ----
// Constants for the pad mode block: register addresses, reset values,
// mode encodings and host interface select codes.
// Assumes the processor register space is an 8-bit address, 8-bit data space.
// Operation
// - Two mode registers and value register per port.
// - Mode bits A,B pick drain, quasi, input, push-pull.
// - Reset leaves every port 3 and port 7 pin quasi-bidirectional.
// - Value write sets outputs, read returns pins.
// - Open-drain value zero pulls pin low.
// - Open-drain value one leaves pin floating.
// - Quasi write pulses strong pull-up one cycle.
// - Quasi hold enable follows sensed pad level.
// - Quasi very weak pull-up follows value bit.
// - High-impedance input connects no pull elements.
// - Push-pull drives value; read returns output value.
// - Hard power down forces port 7 quasi.
// - Hard power down forces port 3 quasi.
// - Processor power down forces interrupt-0 hold on.
// - Two-bit host select loaded from select pads.
// - I2C select makes clock, data open-drain.
// - Fast UART select: receive input, transmit push-pull.
// - SPI select: three inputs, MISO push-pull.
`ifndef GPM_CONSTS_VH
`define GPM_CONSTS_VH

// Register addresses in the processor register space.
`define GPM_ADDR_P3_VALUE   8'hb0
`define GPM_ADDR_P7_MODE_A  8'hf4
`define GPM_ADDR_P7_MODE_B  8'hf5
`define GPM_ADDR_P7_VALUE   8'hf7
`define GPM_ADDR_P3_MODE_A  8'hfc
`define GPM_ADDR_P3_MODE_B  8'hfd
`define GPM_ADDR_HOST_CFG   8'hab

// Reset values.
`define GPM_RST_MODE_A      8'hff
`define GPM_RST_MODE_B      8'h00
`define GPM_RST_VALUE       8'hff
`define GPM_RST_HOST_CFG    8'h00
`define GPM_RDATA_UNMAPPED  8'h00

// Host select field position and codes.
`define GPM_HOST_SEL_LSB    0
`define GPM_HOST_SEL_HSU    2'h0
`define GPM_HOST_SEL_I2C    2'h1
`define GPM_HOST_SEL_SPI    2'h2

// Interrupt-0 pin index within port 3.
`define GPM_INT0_BIT        2

`endif

// ---- design/gpm_host_mux.v ----
// Mode bits for the four host interface pads from the host select field.
// Assumes pad 0 = SDA/NSS/UART receive, pad 1 = SCL/MISO/UART transmit,
// pad 2 = MOSI, pad 3 = SCK.
`timescale 1ns/1ps
`default_nettype none
`include "gpm_consts.vh"
module gpm_host_mux (
    // Select.
    input  wire [1:0] host_sel_in,
    // Per-pad mode bits.
    output reg  [3:0] mode_a_out,
    output reg  [3:0] mode_b_out
);
    // One interface at a time; unused pads sit as inputs.
    always @* begin
        mode_a_out = 4'h0;
        mode_b_out = 4'hf;
        case (host_sel_in)
            `GPM_HOST_SEL_I2C: begin
                mode_a_out = 4'h0;
                mode_b_out = 4'hc;
            end
            `GPM_HOST_SEL_HSU: begin
                mode_a_out = 4'h2;
                mode_b_out = 4'hf;
            end
            `GPM_HOST_SEL_SPI: begin
                mode_a_out = 4'h2;
                mode_b_out = 4'hf;
            end
            default: begin
                mode_a_out = 4'h0;
                mode_b_out = 4'hf;
            end
        endcase
    end
endmodule
`default_nettype wire

// ---- design/gpm_pad_cell.v ----
// Drive decode for one pad from its two mode bits and its value bit.
// Assumes the pad cell outside resolves drive, hold and pull-up enables.
`timescale 1ns/1ps
`default_nettype none
module gpm_pad_cell (
    // Configuration.
    input  wire mode_a_in,
    input  wire mode_b_in,
    input  wire value_in,
    input  wire strong_pulse_in,
    // Overrides.
    input  wire force_quasi_in,
    input  wire force_hold_in,
    // Pad sense.
    input  wire pad_level_in,
    // Pad controls.
    output reg  pin_out_out,
    output reg  pin_oe_out,
    output reg  pull_down_en_n_out,
    output reg  weak_hold_out,
    output reg  very_weak_pu_out,
    output reg  read_level_out
);
    // Mode decode; only this pin's own bits are used.
    always @* begin
        pin_out_out      = 1'b0;
        pin_oe_out       = 1'b0;
        weak_hold_out    = 1'b0;
        very_weak_pu_out = 1'b0;
        read_level_out   = pad_level_in;
        if (force_quasi_in) begin
            // Power-down quasi: no strong drive, pull-up on, hold follows pad.
            very_weak_pu_out = 1'b1;
            weak_hold_out    = pad_level_in;
        end else begin
            case ({mode_b_in, mode_a_in})
                2'h0: begin
                    // Open drain: zero pulls low, one floats.
                    pin_oe_out = ~value_in;
                end
                2'h1: begin
                    // Quasi: strong one for the write pulse, strong zero when cleared.
                    pin_out_out      = strong_pulse_in;
                    pin_oe_out       = strong_pulse_in | ~value_in;
                    weak_hold_out    = pad_level_in;
                    very_weak_pu_out = value_in;
                end
                2'h2: begin
                    // High-impedance input: nothing connected.
                    pin_oe_out = 1'b0;
                end
                default: begin
                    // Push-pull: continuous drive, read back the output value.
                    pin_out_out    = value_in;
                    pin_oe_out     = 1'b1;
                    read_level_out = value_in;
                end
            endcase
        end
        if (force_hold_in) begin
            weak_hold_out = 1'b1;
        end
        pull_down_en_n_out = ~(pin_oe_out & ~pin_out_out);
    end
endmodule
`default_nettype wire

// ---- design/gpm_pad_mode.v ----
// Pad mode controller for general purpose ports 3 and 7 and the host pads.
// Holds the mode and value registers in the processor register space and
// decodes them into per-pad drive, hold and pull-up controls.
// Assumes one-cycle write and read strobes synchronous to clk_sys_in.
`timescale 1ns/1ps
`default_nettype none
`include "gpm_consts.vh"
module gpm_pad_mode #(
    parameter P3_PINS = 6,
    parameter P7_PINS = 3
) (
    // Clock and reset.
    input  wire               clk_sys_in,
    input  wire               rst_in,
    // Processor register access.
    input  wire [7:0]         sfr_addr_in,
    input  wire [7:0]         sfr_wdata_in,
    input  wire               sfr_wr_in,
    input  wire               sfr_rd_in,
    output reg  [7:0]         sfr_rdata_out,
    // Power state.
    input  wire               hard_power_down_in,
    input  wire               processor_power_down_in,
    // Port 3 pads.
    input  wire [P3_PINS-1:0] p3_pad_level_in,
    output wire [P3_PINS-1:0] p3_pin_out,
    output wire [P3_PINS-1:0] p3_pin_oe_out,
    output wire [P3_PINS-1:0] p3_pull_down_en_n_out,
    output wire [P3_PINS-1:0] p3_weak_hold_out,
    output wire [P3_PINS-1:0] p3_very_weak_pu_out,
    // Port 7 pads.
    input  wire [P7_PINS-1:0] p7_pad_level_in,
    output wire [P7_PINS-1:0] p7_pin_out,
    output wire [P7_PINS-1:0] p7_pin_oe_out,
    output wire [P7_PINS-1:0] p7_pull_down_en_n_out,
    output wire [P7_PINS-1:0] p7_weak_hold_out,
    output wire [P7_PINS-1:0] p7_very_weak_pu_out,
    // Host interface pads.
    input  wire [3:0]         host_pad_value_in,
    input  wire [3:0]         host_pad_level_in,
    output wire [3:0]         host_pin_out,
    output wire [3:0]         host_pin_oe_out,
    output wire [3:0]         host_pull_down_en_n_out,
    output wire [3:0]         host_weak_hold_out,
    output wire [3:0]         host_very_weak_pu_out,
    output wire [1:0]         host_sel_out
);

    // Register state.
    reg  [7:0]         p3_mode_a_q;
    reg  [7:0]         p3_mode_b_q;
    reg  [7:0]         p3_value_q;
    reg  [7:0]         p7_mode_a_q;
    reg  [7:0]         p7_mode_b_q;
    reg  [7:0]         p7_value_q;
    reg  [7:0]         host_cfg_q;
    reg  [7:0]         p3_pulse_q;
    reg  [7:0]         p7_pulse_q;
    reg  [7:0]         rdata_d;

    // Per-pin read levels from the pad decoders, host pad mode bits and readback words.
    wire [P3_PINS-1:0] p3_read_level;
    wire [P7_PINS-1:0] p7_read_level;
    wire [3:0]         host_mode_a;
    wire [3:0]         host_mode_b;
    wire [7:0]         p3_read_word;
    wire [7:0]         p7_read_word;

    // Write strobes for the two value registers.
    wire               wr_p3_value;
    wire               wr_p7_value;

    assign wr_p3_value = sfr_wr_in && (sfr_addr_in == `GPM_ADDR_P3_VALUE);
    assign wr_p7_value = sfr_wr_in && (sfr_addr_in == `GPM_ADDR_P7_VALUE);

    // Register writes; reset leaves all port 3 and port 7 pins quasi-bidirectional.
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            p3_mode_a_q <= `GPM_RST_MODE_A;
            p3_mode_b_q <= `GPM_RST_MODE_B;
            p3_value_q  <= `GPM_RST_VALUE;
            p7_mode_a_q <= `GPM_RST_MODE_A;
            p7_mode_b_q <= `GPM_RST_MODE_B;
            p7_value_q  <= `GPM_RST_VALUE;
            host_cfg_q  <= `GPM_RST_HOST_CFG;
        end else if (sfr_wr_in) begin
            // Six per-port registers, one bit per pin, and the host configuration register.
            case (sfr_addr_in)
                `GPM_ADDR_P3_MODE_A: begin
                    p3_mode_a_q <= sfr_wdata_in;
                end
                `GPM_ADDR_P3_MODE_B: begin
                    p3_mode_b_q <= sfr_wdata_in;
                end
                `GPM_ADDR_P3_VALUE: begin
                    p3_value_q <= sfr_wdata_in;
                end
                `GPM_ADDR_P7_MODE_A: begin
                    p7_mode_a_q <= sfr_wdata_in;
                end
                `GPM_ADDR_P7_MODE_B: begin
                    p7_mode_b_q <= sfr_wdata_in;
                end
                `GPM_ADDR_P7_VALUE: begin
                    p7_value_q <= sfr_wdata_in;
                end
                `GPM_ADDR_HOST_CFG: begin
                    host_cfg_q <= sfr_wdata_in;
                end
                default: begin
                    host_cfg_q <= host_cfg_q;
                end
            endcase
        end
    end

    // Strong pull-up pulse: one clock after a value write, for quasi pins
    // written with one; it clears itself on the next edge.
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            p3_pulse_q <= 8'h00;
            p7_pulse_q <= 8'h00;
        end else begin
            p3_pulse_q <= {8{wr_p3_value}} & sfr_wdata_in & p3_mode_a_q & ~p3_mode_b_q;
            p7_pulse_q <= {8{wr_p7_value}} & sfr_wdata_in & p7_mode_a_q & ~p7_mode_b_q;
        end
    end

    // Port 3 pads; interrupt-0 pin gets the processor power-down hold.
    genvar n;
    generate
        for (n = 0; n < P3_PINS; n = n + 1) begin : g_p3
            gpm_pad_cell u_cell (
                .mode_a_in          (p3_mode_a_q[n]),
                .mode_b_in          (p3_mode_b_q[n]),
                .value_in           (p3_value_q[n]),
                .strong_pulse_in    (p3_pulse_q[n]),
                .force_quasi_in     (hard_power_down_in),
                .force_hold_in      ((n == `GPM_INT0_BIT) && processor_power_down_in),
                .pad_level_in       (p3_pad_level_in[n]),
                .pin_out_out        (p3_pin_out[n]),
                .pin_oe_out         (p3_pin_oe_out[n]),
                .pull_down_en_n_out (p3_pull_down_en_n_out[n]),
                .weak_hold_out      (p3_weak_hold_out[n]),
                .very_weak_pu_out   (p3_very_weak_pu_out[n]),
                .read_level_out     (p3_read_level[n])
            );
        end
    endgenerate

    // Port 7 pads, including the host interrupt pin at index 0.
    generate
        for (n = 0; n < P7_PINS; n = n + 1) begin : g_p7
            gpm_pad_cell u_cell (
                .mode_a_in          (p7_mode_a_q[n]),
                .mode_b_in          (p7_mode_b_q[n]),
                .value_in           (p7_value_q[n]),
                .strong_pulse_in    (p7_pulse_q[n]),
                .force_quasi_in     (hard_power_down_in),
                .force_hold_in      (1'b0),
                .pad_level_in       (p7_pad_level_in[n]),
                .pin_out_out        (p7_pin_out[n]),
                .pin_oe_out         (p7_pin_oe_out[n]),
                .pull_down_en_n_out (p7_pull_down_en_n_out[n]),
                .weak_hold_out      (p7_weak_hold_out[n]),
                .very_weak_pu_out   (p7_very_weak_pu_out[n]),
                .read_level_out     (p7_read_level[n])
            );
        end
    endgenerate

    // Host select field written by firmware from the select pads.
    assign host_sel_out = host_cfg_q[`GPM_HOST_SEL_LSB+1:`GPM_HOST_SEL_LSB];

    // Host pad modes follow the selected interface.
    gpm_host_mux u_host_mux (
        .host_sel_in (host_sel_out),
        .mode_a_out  (host_mode_a),
        .mode_b_out  (host_mode_b)
    );

    // Host pads driven by the selected link's own output values.
    generate
        for (n = 0; n < 4; n = n + 1) begin : g_host
            gpm_pad_cell u_cell (
                .mode_a_in          (host_mode_a[n]),
                .mode_b_in          (host_mode_b[n]),
                .value_in           (host_pad_value_in[n]),
                .strong_pulse_in    (1'b0),
                .force_quasi_in     (1'b0),
                .force_hold_in      (1'b0),
                .pad_level_in       (host_pad_level_in[n]),
                .pin_out_out        (host_pin_out[n]),
                .pin_oe_out         (host_pin_oe_out[n]),
                .pull_down_en_n_out (host_pull_down_en_n_out[n]),
                .weak_hold_out      (host_weak_hold_out[n]),
                .very_weak_pu_out   (host_very_weak_pu_out[n]),
                .read_level_out     ()
            );
        end
    endgenerate

    // Value readback words; bits with no pad read zero.
    generate
        for (n = 0; n < 8; n = n + 1) begin : g_rd
            if (n < P3_PINS) begin : g_p3_on
                assign p3_read_word[n] = p3_read_level[n];
            end else begin : g_p3_off
                assign p3_read_word[n] = 1'b0;
            end
            if (n < P7_PINS) begin : g_p7_on
                assign p7_read_word[n] = p7_read_level[n];
            end else begin : g_p7_off
                assign p7_read_word[n] = 1'b0;
            end
        end
    endgenerate

    // Read mux; unmapped addresses read zero.
    always @* begin
        case (sfr_addr_in)
            `GPM_ADDR_P3_MODE_A: rdata_d = p3_mode_a_q;
            `GPM_ADDR_P3_MODE_B: rdata_d = p3_mode_b_q;
            `GPM_ADDR_P3_VALUE:  rdata_d = p3_read_word;
            `GPM_ADDR_P7_MODE_A: rdata_d = p7_mode_a_q;
            `GPM_ADDR_P7_MODE_B: rdata_d = p7_mode_b_q;
            `GPM_ADDR_P7_VALUE:  rdata_d = p7_read_word;
            `GPM_ADDR_HOST_CFG:  rdata_d = host_cfg_q;
            default:             rdata_d = `GPM_RDATA_UNMAPPED;
        endcase
    end

    // Read data registered on the read strobe, held until the next read.
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            sfr_rdata_out <= `GPM_RDATA_UNMAPPED;
        end else if (sfr_rd_in) begin
            sfr_rdata_out <= rdata_d;
        end
    end

endmodule
`default_nettype wire
